/* File: verilog/nch_cfg.svh */
// Purpose: constants of the flash command port host controller
// Assumes: 100 MHz system clock, one target device on the port
// Notes: timing figures are in ns; cycle counts are derived in the module
`ifndef NCH_CFG_SVH
`define NCH_CFG_SVH
// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define NCH_CMD_READ 8'h00
`define NCH_CMD_READ_GO 8'h30
`define NCH_CMD_READ_CB_GO 8'h35
`define NCH_CMD_ID 8'h90
`define NCH_CMD_RESET 8'hFF
`define NCH_CMD_PROG 8'h80
`define NCH_CMD_PROG_GO 8'h10
`define NCH_CMD_CACHE_GO 8'h15
`define NCH_CMD_RAND_IN 8'h85
`define NCH_CMD_ERASE 8'h60
`define NCH_CMD_ERASE_GO 8'hD0
`define NCH_CMD_RAND_OUT 8'h05
`define NCH_CMD_RAND_OUT_GO 8'hE0
`define NCH_CMD_STATUS 8'h70
// ----------------------------------------------------------------------
// address layout and timing
// ----------------------------------------------------------------------
`define NCH_ADDR_W 29
`define NCH_ROW_FIRST 3'h2
`define NCH_COL_CYCLES 3'h2
`define NCH_ROW_CYCLES 3'h3
`define NCH_ALL_CYCLES 3'h5
`define NCH_PAGE_BYTES 2112
`define NCH_CLK_NS 10
`define NCH_T_STROBE_NS 30
`define NCH_T_WB_NS 100
`endif

/* File: verilog/nch_pkg.sv */
// Purpose: types of the flash command port host controller
// Assumes: nch_cfg.svh supplies every number
// Notes: the operation table lives here; the bench keeps its own copy to check against
`include "nch_cfg.svh"
package nch_pkg;
  // ----------------------------------------------------------------------
  // operations, states and bundles
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    NCH_OP_READ, NCH_OP_READ_CB, NCH_OP_PROG, NCH_OP_CACHE, NCH_OP_CB_PROG, NCH_OP_ERASE,
    NCH_OP_ID, NCH_OP_RESET, NCH_OP_STATUS, NCH_OP_RAND_IN, NCH_OP_RAND_OUT
  } nch_op_e;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2, ST_WAITB, ST_BUSY, ST_DOUT, ST_DONE
  } nch_state_e;
  typedef struct packed {
    nch_op_e op;
    logic [`NCH_ADDR_W-1:0] addr;
    logic [11:0] len;
  } nch_req_s;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic [7:0] io_out;
    logic io_oe;
  } nch_pins_s;
  typedef struct packed {
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic has_cmd2;
    logic [2:0] afirst;
    logic [2:0] acount;
    logic din;
    logic dout;
    logic wait_rdy;
  } nch_seq_s;

  // sequence of bus cycles for each operation
  function automatic nch_seq_s seq_of(input nch_op_e op);
    nch_seq_s s;
    s = '{cmd1: `NCH_CMD_STATUS, cmd2: 8'h00, has_cmd2: 1'b0, afirst: 3'h0, acount: 3'h0,
          din: 1'b0, dout: 1'b0, wait_rdy: 1'b0};
    unique case (op)
      NCH_OP_READ: s = '{`NCH_CMD_READ, `NCH_CMD_READ_GO, 1'b1, 3'h0, `NCH_ALL_CYCLES, 1'b0, 1'b1, 1'b1};
      NCH_OP_READ_CB: s = '{`NCH_CMD_READ, `NCH_CMD_READ_CB_GO, 1'b1, 3'h0, `NCH_ALL_CYCLES, 1'b0, 1'b0, 1'b1};
      NCH_OP_PROG: s = '{`NCH_CMD_PROG, `NCH_CMD_PROG_GO, 1'b1, 3'h0, `NCH_ALL_CYCLES, 1'b1, 1'b0, 1'b1};
      NCH_OP_CACHE: s = '{`NCH_CMD_PROG, `NCH_CMD_CACHE_GO, 1'b1, 3'h0, `NCH_ALL_CYCLES, 1'b1, 1'b0, 1'b1};
      NCH_OP_CB_PROG: s = '{`NCH_CMD_RAND_IN, `NCH_CMD_PROG_GO, 1'b1, 3'h0, `NCH_ALL_CYCLES, 1'b1, 1'b0, 1'b1};
      NCH_OP_ERASE: s = '{`NCH_CMD_ERASE, `NCH_CMD_ERASE_GO, 1'b1, `NCH_ROW_FIRST, `NCH_ROW_CYCLES, 1'b0, 1'b0, 1'b1};
      NCH_OP_ID: s = '{`NCH_CMD_ID, 8'h00, 1'b0, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0};
      NCH_OP_RESET: s = '{`NCH_CMD_RESET, 8'h00, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b1};
      NCH_OP_STATUS: s = '{`NCH_CMD_STATUS, 8'h00, 1'b0, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0};
      NCH_OP_RAND_IN: s = '{`NCH_CMD_RAND_IN, 8'h00, 1'b0, 3'h0, `NCH_COL_CYCLES, 1'b1, 1'b0, 1'b0};
      NCH_OP_RAND_OUT: s = '{`NCH_CMD_RAND_OUT, `NCH_CMD_RAND_OUT_GO, 1'b1, 3'h0, `NCH_COL_CYCLES, 1'b0, 1'b1, 1'b0};
      default: s = s;
    endcase
    return s;
  endfunction : seq_of

  // address byte for cycle idx, unused bits forced low
  function automatic logic [7:0] addr_byte(input logic [`NCH_ADDR_W-1:0] a, input logic [2:0] idx);
    unique case (idx)
      3'h0: return a[7:0];
      3'h1: return {4'h0, a[11:8]};
      3'h2: return a[19:12];
      3'h3: return a[27:20];
      default: return {7'h00, a[28]};
    endcase
  endfunction : addr_byte
endpackage : nch_pkg

/* File: verilog/nch_host.sv */
// Purpose: host controller that drives a page flash through its multiplexed port
// Assumes: one device, ready/busy pin pulled up outside, strobe tick of DIV cycles
// Notes: pin outputs lag the sequencer state by one clock; all outputs are flops
`timescale 1ns/1ps
`include "nch_cfg.svh"
module nch_host #(
  parameter int DIV = (`NCH_T_STROBE_NS + `NCH_CLK_NS - 1) / `NCH_CLK_NS,
  parameter int TWB_CYC = (`NCH_T_WB_NS + `NCH_CLK_NS - 1) / `NCH_CLK_NS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // request
  input wire nch_pkg::nch_req_s req,
  input wire logic req_valid,
  output logic req_ready,
  output logic done,
  // write data stream
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read data stream
  output logic [7:0] rd_data,
  output logic rd_valid,
  // device pins
  output nch_pkg::nch_pins_s pins,
  input wire logic [7:0] io_in,
  input wire logic rb_in
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  nch_pkg::nch_state_e state, next_state, st_after_c2, st_after_din, st_after_addr;
  nch_pkg::nch_req_s cur;
  nch_pkg::nch_seq_s seq;
  nch_pkg::nch_pins_s pin_w;
  logic [7:0] div, wcnt, dlatch;
  logic [7:0] io_s1, io_s2, io_s3;
  logic rb_s1, rb_s2, rb_s3, rb_level, tick, pre;
  logic [1:0] ph, next_ph;
  logic [2:0] aidx, next_aidx, alast;
  logic [11:0] cnt, next_cnt;
  logic take_req, take_wr, take_rd, byte_state, last_ph;

  // ----------------------------------------------------------------------
  // strobe divider and pin synchronisers
  // ----------------------------------------------------------------------
  assign pre = (div == 8'(DIV - 1));
  // divider free-runs; phases advance only on its tick, which comes once every DIV cycles
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div <= 8'h00;
      tick <= 1'b0;
    end else begin
      div <= pre ? 8'h00 : 8'(div + 8'h01);
      tick <= pre;
    end
  end

  // three stages; stage one feeds only stage two
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {io_s1, io_s2, io_s3} <= {8'h00, 8'h00, 8'h00};
      {rb_s1, rb_s2, rb_s3, rb_level} <= 4'hF;
    end else begin
      {io_s1, io_s2, io_s3} <= {io_in, io_s1, io_s2};
      {rb_s1, rb_s2, rb_s3} <= {rb_in, rb_s1, rb_s2};
      if (rb_s2 == rb_s3) rb_level <= rb_s3; // change counts once stages agree
    end
  end

  // ----------------------------------------------------------------------
  // sequencer decode
  // ----------------------------------------------------------------------
  assign take_req = (state == nch_pkg::ST_IDLE) && req_valid && req_ready;
  assign take_wr = (state == nch_pkg::ST_DIN) && (ph == 2'h0) && wr_valid && wr_ready;
  assign take_rd = (state == nch_pkg::ST_DOUT) && (ph == 2'h3) && tick && (io_s2 == io_s3);
  assign byte_state = (state == nch_pkg::ST_CMD1) || (state == nch_pkg::ST_ADDR) ||
                      (state == nch_pkg::ST_CMD2) || (state == nch_pkg::ST_DIN);
  assign last_ph = tick && (ph == 2'h1);
  assign alast = 3'(seq.afirst + seq.acount - 3'h1); // only the cycles the op needs
  // what follows each phase of an operation
  assign st_after_c2 = seq.wait_rdy ? nch_pkg::ST_WAITB :
                       (seq.dout && cur.len != 12'h000) ? nch_pkg::ST_DOUT : nch_pkg::ST_DONE;
  assign st_after_din = seq.has_cmd2 ? nch_pkg::ST_CMD2 : st_after_c2;
  assign st_after_addr = (seq.din && cur.len != 12'h000) ? nch_pkg::ST_DIN : st_after_din;

  // next state; byte cycles move only on divider ticks
  always_comb begin
    next_state = state;
    next_ph = ph;
    next_aidx = aidx;
    next_cnt = cnt;
    unique case (state)
      nch_pkg::ST_IDLE: if (take_req) next_state = nch_pkg::ST_CMD1;
      nch_pkg::ST_CMD1: if (last_ph) next_state = (seq.acount != 3'h0) ? nch_pkg::ST_ADDR : st_after_addr;
      nch_pkg::ST_ADDR: begin
        if (last_ph) begin
          if (aidx == alast) next_state = st_after_addr;
          else next_aidx = 3'(aidx + 3'h1);
        end
      end
      nch_pkg::ST_DIN: begin
        if (last_ph) begin
          if (cnt == 12'h001) next_state = st_after_din;
          else next_cnt = 12'(cnt - 12'h001);
        end
      end
      nch_pkg::ST_CMD2: if (last_ph) next_state = st_after_c2;
      nch_pkg::ST_WAITB: if (wcnt == 8'(TWB_CYC - 1)) next_state = nch_pkg::ST_BUSY;
      nch_pkg::ST_BUSY: begin
        if (rb_level) next_state = (seq.dout && cur.len != 12'h000) ? nch_pkg::ST_DOUT : nch_pkg::ST_DONE;
      end
      nch_pkg::ST_DOUT: begin
        if (take_rd) begin
          if (cnt == 12'h001) next_state = nch_pkg::ST_DONE;
          else next_cnt = 12'(cnt - 12'h001); // device column steps with each strobe
        end
      end
      nch_pkg::ST_DONE: next_state = nch_pkg::ST_IDLE;
    endcase
    // phase walk: 0 setup, 1 strobe low; reads hold the strobe low for 1..3
    if (byte_state && tick && (ph == 2'h0) && (state != nch_pkg::ST_DIN || take_wr)) next_ph = 2'h1;
    else if (byte_state && last_ph) next_ph = 2'h0;
    else if (state == nch_pkg::ST_DOUT && tick && ph != 2'h3) next_ph = 2'(ph + 2'h1);
    else if (take_rd) next_ph = 2'h0;
    if (next_state != state) begin
      next_ph = 2'h0;
      next_cnt = cur.len;
      if (next_state == nch_pkg::ST_ADDR) next_aidx = seq.afirst; // erase starts at row
    end
  end

  // ----------------------------------------------------------------------
  // pin values from state
  // ----------------------------------------------------------------------
  assign pin_w.ce_n = (state == nch_pkg::ST_IDLE) || (state == nch_pkg::ST_DONE);
  assign pin_w.cle = (state == nch_pkg::ST_CMD1) || (state == nch_pkg::ST_CMD2);
  assign pin_w.ale = (state == nch_pkg::ST_ADDR);
  // strobe rises one clock before io moves, so each byte still holds at its latch edge
  assign pin_w.we_n = !(byte_state && ph == 2'h1 && !tick);
  assign pin_w.output_strobe_n = !(state == nch_pkg::ST_DOUT && ph != 2'h0);
  assign pin_w.wp_n = 1'b1;
  assign pin_w.io_oe = byte_state;
  // command cycles put only table codes on the port
  assign pin_w.io_out = (state == nch_pkg::ST_CMD1) ? seq.cmd1 :
                        (state == nch_pkg::ST_CMD2) ? seq.cmd2 :
                        (state == nch_pkg::ST_ADDR) ? nch_pkg::addr_byte(cur.addr, aidx) : dlatch;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // sequencer state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= nch_pkg::ST_IDLE;
      {ph, aidx, cnt} <= {2'h0, 3'h0, 12'h000};
      wcnt <= 8'h00;
    end else begin
      state <= next_state;
      {ph, aidx, cnt} <= {next_ph, next_aidx, next_cnt};
      wcnt <= (state == nch_pkg::ST_WAITB) ? 8'(wcnt + 8'h01) : 8'h00;
    end
  end

  // request capture and data holding
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      seq <= '0;
      dlatch <= 8'h00;
      rd_data <= 8'h00;
    end else begin
      if (take_req) cur <= req;
      if (take_req) seq <= nch_pkg::seq_of(req.op);
      if (take_wr) dlatch <= wr_data;
      if (take_rd) rd_data <= io_s3;
    end
  end

  // handshakes; no new request while the device reports busy
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {req_ready, wr_ready, rd_valid, done} <= 4'h0;
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, output_strobe_n: 1'b1,
                wp_n: 1'b0, io_out: 8'h00, io_oe: 1'b0};
    end else begin
      // stays low through the done cycle, so a request is never offered and then withdrawn
      req_ready <= (next_state == nch_pkg::ST_IDLE) && (state == nch_pkg::ST_IDLE) && rb_level;
      wr_ready <= (state == nch_pkg::ST_DIN) && (ph == 2'h0) && pre; // one cycle, on the tick
      rd_valid <= take_rd;
      done <= (state == nch_pkg::ST_DONE);
      pins <= pin_w;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_we_needs_ce: assert property (!pins.we_n |-> !pins.ce_n && pins.io_oe) else $error("strobe without select");
  a_we_low_len: assert property ($fell(pins.we_n) |-> !pins.we_n [*2]) else $error("write strobe too short");
  a_latch_excl: assert property (!(pins.cle && pins.ale)) else $error("both latch selects high");
  // checked a cycle ahead of the pins, where aidx still names the byte on io
  a_addr_pad_low: assert property (pin_w.ale |-> (aidx != 3'h1 || pin_w.io_out[7:4] == 4'h0) &&
    (aidx != 3'h4 || pin_w.io_out[7:1] == 7'h00)) else $error("address pad bits set");
  a_addr_count: assert property ($past(state) == nch_pkg::ST_ADDR && state != nch_pkg::ST_ADDR |->
    $past(aidx) == $past(alast)) else $error("address cycles miscounted");
  a_erase_row: assert property (state == nch_pkg::ST_ADDR && seq.cmd1 == `NCH_CMD_ERASE |-> aidx >= `NCH_ROW_FIRST)
    else $error("erase sent a column cycle");
  a_read_conf: assert property (state == nch_pkg::ST_CMD2 && seq.cmd1 == `NCH_CMD_READ |->
    seq.cmd2 == `NCH_CMD_READ_GO || seq.cmd2 == `NCH_CMD_READ_CB_GO) else $error("bad read confirm");
  a_busy_no_req: assert property (!rb_level |-> ##1 !req_ready) else $error("request offered while busy");
  a_rd_no_drive: assert property (!pins.output_strobe_n |-> !pins.io_oe) else $error("driving during read");
  a_busy_exit: assert property (state == nch_pkg::ST_BUSY && rb_level |=> state != nch_pkg::ST_BUSY)
    else $error("ready not seen");
  a_done_pulse: assert property (done |=> !done && (req_ready || !$past(rb_level)))
    else $error("done not closed");

  c_read: cover property (state == nch_pkg::ST_DOUT && seq.cmd2 == `NCH_CMD_READ_GO ##[1:400] done);
  c_prog: cover property (state == nch_pkg::ST_CMD2 && seq.cmd2 == `NCH_CMD_PROG_GO ##[1:400] done);
  c_erase: cover property (state == nch_pkg::ST_BUSY && seq.cmd1 == `NCH_CMD_ERASE ##[1:400] done);
  c_status: cover property (rd_valid && seq.cmd1 == `NCH_CMD_STATUS);
endmodule : nch_host

/* File: sim/nch_dev_model.sv */
// Purpose: behavioural model of the page flash seen at the host pins
// Assumes: io is the resolved wire level, ready/busy is open drain
// Notes: the array is not modelled; the page buffer stands for every page
`timescale 1ns/1ps
module nch_dev_model #(
  parameter int BUSY_NS = 2000,
  parameter logic [7:0] ID_BYTE = 8'h5C, // arbitrary value
  parameter logic [7:0] STAT = 8'hE0
) (
  // pins from host
  input wire nch_pkg::nch_pins_s pins,
  input wire logic [7:0] io,
  // lines back to host
  output logic [7:0] io_drv,
  output logic io_en,
  output logic busy
);
  logic [7:0] pbuf [0:2111];
  logic [9:0] log_q [$];
  logic [7:0] last_cmd;
  logic [11:0] col;
  logic [2:0] acnt;
  int bad;
  event go;
  // buffer content known to the bench
  initial begin
    busy = 1'b0;
    bad = 0;
    col = 12'h000;
    acnt = 3'h0;
    last_cmd = 8'hFF;
    io_drv = 8'h00;
    for (int i = 0; i < 2112; i++) pbuf[i] = i[7:0] ^ 8'h3C;
  end
  // bytes latch on the strobe rise, only while selected
  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      if (busy && !(pins.cle && (io == 8'hFF || io == 8'h70))) bad++;
      if (pins.cle) begin
        log_q.push_back({2'h1, io});
        if (!(io inside {8'h00, 8'h30, 8'h35, 8'h90, 8'hFF, 8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0, 8'h05,
                         8'hE0, 8'h70})) bad++;
        last_cmd = io;
        acnt = 3'h0;
        if (io inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF}) ->go;
      end else if (pins.ale) begin
        log_q.push_back({2'h2, io});
        if (last_cmd != 8'h60 && acnt == 3'h0) col[7:0] = io;
        if (last_cmd != 8'h60 && acnt == 3'h1) col[11:8] = io[3:0];
        acnt++;
      end else begin
        log_q.push_back({2'h3, io});
        if (col < 12'd2112) pbuf[col] = io;
        col++;
      end
    end
  end
  // each fall of the read strobe presents the next byte
  always @(negedge pins.output_strobe_n) begin
    if (!pins.ce_n) begin
      io_drv = (last_cmd == 8'h90) ? ID_BYTE : (last_cmd == 8'h70) ? STAT : pbuf[col];
      if (last_cmd != 8'h90 && last_cmd != 8'h70) col++;
    end
  end
  assign io_en = !pins.ce_n && !pins.output_strobe_n;
  // ready/busy low for a fixed span after confirms 30h, 35h, 10h, 15h, D0h and reset FFh, not after E0h
  always begin
    @(go);
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
endmodule : nch_dev_model

/* File: sim/nch_host_tb_top.sv */
// Purpose: self-checking bench for the flash port host controller
// Assumes: device model on the pins, pull-up on ready/busy
// Notes: expected bytes come from a bench table, never from the design
`timescale 1ns/1ps
module nch_host_tb_top;
  logic sys_clk, nrst, req_valid, req_ready, done, wr_ready, rd_valid, dev_en, busy;
  logic wr_valid = 1'b0;
  logic [7:0] rd_data, io_w, dev_io;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] io_q = 8'h00;
  logic [31:0] seed;
  logic [31:0] seed2 = 32'd59 ^ 32'h0000_00FF;
  nch_pkg::nch_req_s req;
  nch_pkg::nch_pins_s pins;
  int err_count, checks;
  logic [9:0] eq [$];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [7:0] xq [$];
  logic [7:0] mir [0:2111];
  // released bus never keeps its last value
  assign io_w = pins.io_oe ? pins.io_out : (dev_en ? dev_io : ~io_q);
  always @(posedge sys_clk) io_q <= io_w;
  nch_host #(.DIV(3), .TWB_CYC(10)) uut (.sys_clk(sys_clk), .nrst(nrst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .done(done), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .pins(pins), .io_in(io_w), .rb_in(~busy));
  nch_dev_model #(.BUSY_NS(2000), .ID_BYTE(8'h5C), .STAT(8'hE0)) dev (.pins(pins), .io(io_w),
    .io_drv(dev_io), .io_en(dev_en), .busy(busy));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // {cmd1, cmd2, has cmd2, first addr cycle, addr cycles, data in, data out}
  function automatic logic [24:0] tbl(input nch_pkg::nch_op_e op);
    case (op)
      nch_pkg::NCH_OP_READ: return {8'h00, 8'h30, 1'b1, 3'd0, 3'd5, 2'b01};
      nch_pkg::NCH_OP_READ_CB: return {8'h00, 8'h35, 1'b1, 3'd0, 3'd5, 2'b00};
      nch_pkg::NCH_OP_PROG: return {8'h80, 8'h10, 1'b1, 3'd0, 3'd5, 2'b10};
      nch_pkg::NCH_OP_CACHE: return {8'h80, 8'h15, 1'b1, 3'd0, 3'd5, 2'b10};
      nch_pkg::NCH_OP_CB_PROG: return {8'h85, 8'h10, 1'b1, 3'd0, 3'd5, 2'b10};
      nch_pkg::NCH_OP_ERASE: return {8'h60, 8'hD0, 1'b1, 3'd2, 3'd3, 2'b00};
      nch_pkg::NCH_OP_ID: return {8'h90, 8'h00, 1'b0, 3'd0, 3'd0, 2'b01};
      nch_pkg::NCH_OP_RESET: return {8'hFF, 8'h00, 1'b0, 3'd0, 3'd0, 2'b00};
      nch_pkg::NCH_OP_STATUS: return {8'h70, 8'h00, 1'b0, 3'd0, 3'd0, 2'b01};
      nch_pkg::NCH_OP_RAND_IN: return {8'h85, 8'h00, 1'b0, 3'd0, 3'd2, 2'b10};
      default: return {8'h05, 8'hE0, 1'b1, 3'd0, 3'd2, 2'b01};
    endcase
  endfunction : tbl
  // address byte of cycle k with unused bits low
  function automatic logic [7:0] abyte(input logic [28:0] a, input int k);
    case (k)
      0: return a[7:0];
      1: return {4'h0, a[11:8]};
      2: return a[19:12];
      3: return a[27:20];
      default: return {7'h00, a[28]};
    endcase
  endfunction : abyte
  task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t port byte %h expected %h", $time, got, exp);
    end
  endtask : cmp10
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t read byte %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  task automatic wrap_up();
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // one whole operation and the check of every byte it moved
  task automatic run_op(input nch_pkg::nch_op_e op, input logic [28:0] a, input logic [11:0] n);
    logic [24:0] t;
    logic [7:0] d;
    int k;
    t = tbl(op);
    eq.delete();
    rq.delete();
    xq.delete();
    dev.log_q.delete();
    eq.push_back({2'h1, t[24:17]});
    for (k = t[7:5]; k < t[7:5] + t[4:2]; k++) eq.push_back({2'h2, abyte(a, k)});
    for (k = 0; t[1] && k < n; k++) begin
      seed = xs(seed);
      d = seed[7:0];
      wq.push_back(d);
      eq.push_back({2'h3, d});
      mir[a[11:0] + k] = d;
    end
    if (t[8]) eq.push_back({2'h1, t[16:9]});
    for (k = 0; t[0] && k < n; k++) xq.push_back(op == nch_pkg::NCH_OP_ID ? 8'h5C :
      op == nch_pkg::NCH_OP_STATUS ? 8'hE0 : mir[a[11:0] + k]);
    @(posedge sys_clk);
    req <= '{op, a, n};
    req_valid <= 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 5000) begin
      @(negedge sys_clk);
      k++;
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 30000) begin
      @(negedge sys_clk);
      k++;
    end
    cmp1(k < 30000, 1'b1);
    cmp1(busy, 1'b0);
    cmp1(dev.bad == 0, 1'b1);
    cmp1(pins.wp_n, 1'b1);
    cmp10(10'(dev.log_q.size()), 10'(eq.size()));
    for (k = 0; k < eq.size() && k < dev.log_q.size(); k++) cmp10(dev.log_q[k], eq[k]);
    cmp8(8'(rq.size()), 8'(xq.size()));
    for (k = 0; k < xq.size() && k < rq.size(); k++) cmp8(rq[k], xq[k]);
  endtask : run_op
  // write stream with random stalls; a raised valid holds until taken
  always @(posedge sys_clk) begin
    seed2 = xs(seed2);
    if (wr_valid === 1'b1 && wr_ready === 1'b1) void'(wq.pop_front());
    if (wr_valid !== 1'b1 || wr_ready === 1'b1) wr_valid <= (wq.size() > 0) && seed2[0];
    wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
  end
  always @(posedge sys_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #(900000);
    err_count++;
    wrap_up();
  end
  initial begin
    logic [28:0] a;
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    seed = 32'd59;
    err_count = 0;
    checks = 0;
    for (int i = 0; i < 2112; i++) mir[i] = i[7:0] ^ 8'h3C;
    repeat (10) @(posedge sys_clk);
    cmp1(pins.ce_n, 1'b1);
    nrst <= 1'b1;
    // program then read back, then the spare bytes at the page end
    seed = xs(seed);
    a = {seed[16:0], 12'(seed[27:16] % 2100)};
    run_op(nch_pkg::NCH_OP_PROG, a, 12'd4);
    run_op(nch_pkg::NCH_OP_READ, a, 12'd4);
    run_op(nch_pkg::NCH_OP_READ, {5'h1F, 12'hFFF, 12'd2110}, 12'd2);
    // every operation once with random address and length
    for (int i = 0; i < 11; i++) begin
      seed = xs(seed);
      a = {seed[31:15], 12'(seed[11:0] % 2100)};
      run_op(nch_pkg::nch_op_e'(i), a, 12'(seed[13:12]));
    end
    wrap_up();
  end
endmodule : nch_host_tb_top
